//--- include/hsac_pkg.sv
// constants and types for the inrush controller alert, control and adc bank
package hsac_pkg;
    localparam logic [3:0] OFS_ALERT  = 4'h2;
    localparam logic [3:0] OFS_CTRL   = 4'h3;
    localparam logic [3:0] OFS_CUR_HI = 4'h4;
    localparam logic [3:0] OFS_CUR_LO = 4'h5;
    localparam logic [3:0] OFS_SEC_HI = 4'h6;
    localparam logic [3:0] OFS_SEC_LO = 4'h7;
    localparam logic [3:0] OFS_AUX_HI = 4'h8;
    localparam logic [3:0] OFS_AUX_LO = 4'h9;

    localparam int BIT_PG_OUT   = 6;
    localparam int BIT_TEST     = 5;
    localparam int BIT_RTY_PBAD = 4;
    localparam int BIT_FET_ON   = 3;
    localparam int BIT_RTY_OC   = 2;
    localparam int BIT_RTY_UV   = 1;
    localparam int BIT_RTY_OV   = 0;
    localparam int BIT_CFG_LO   = 6;
    localparam int BIT_CFG_HI   = 7;

    localparam logic [7:0] ALERT_RST     = 8'h00;
    localparam logic [7:0] ALERT_EN_MASK = 8'hBF;
    localparam logic [7:0] CTRL_RST      = 8'h03;
    localparam logic [7:0] LO_KEEP_MASK  = 8'hC0;
    localparam logic [9:0] RESULT_RST    = 10'h000;

    localparam logic [1:0] LABEL_CUR = 2'h0;
    localparam logic [1:0] LABEL_SEC = 2'h1;
    localparam logic [1:0] LABEL_AUX = 2'h2;

    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        HSAC_PG_OPEN_DRAIN,
        HSAC_PG_GP_OUT,
        HSAC_PG_GP_IN
    } hsac_pgmode_e;

    typedef struct packed {
        logic       valid;
        logic [1:0] label;
        logic [9:0] data;
    } hsac_result_s;

    typedef struct packed {
        logic pbad;
        logic oc;
        logic uv;
        logic ov;
    } hsac_retry_s;

    typedef struct packed {
        logic [7:0]             alert_mask;
        logic [7:0]             ctrl;
        logic [9:0]             cur;
        logic [9:0]             sec;
        logic [9:0]             aux;
        logic [7:0]             rdata;
        logic [SYNC_STAGES-1:0] on_sync;
        logic                   on_level;
        logic [SYNC_STAGES-1:0] pg_sync;
        logic                   pg_level;
        logic                   alert_pull;
        logic                   pg_drive;
        logic                   pg_oe;
        hsac_result_s           bcast;
    } hsac_state_s;
endpackage

//--- design/hsac_regs.sv
// alert mask, control and adc result registers of the inrush controller
`timescale 1ns/1ps
module hsac_regs (
    input  wire logic                  mclk_in,            // 10 MHz clock
    input  wire logic                  sys_rst_in,         // sync reset, high
    input  wire logic                  reg_wr_in,          // write strobe
    input  wire logic                  reg_rd_in,          // read strobe
    input  wire logic [7:0]            reg_addr_in,        // register pointer
    input  wire logic [7:0]            reg_wdata_in,       // write data
    output logic      [7:0]            reg_rdata_out,      // read data
    input  wire logic [7:0]            fault_log_in,       // logged faults
    output logic                       alert_pull_out,     // pull alert low
    input  wire logic                  power_good_in,      // power is good
    input  wire logic                  power_good_io_pin_in,  // pin level
    output logic                       power_good_io_pin_out, // pin drive
    output logic                       power_good_io_pin_oe_out, // drive en
    output logic                       pg_input_level_out, // filtered pin
    input  wire logic                  on_pin_in,          // on/off pin
    input  wire logic                  debounce_done_in,   // start-up done
    output logic                       fet_on_cmd_out,     // pass fet on
    output hsac_pkg::hsac_retry_s      retry_en_out,       // retry enables
    output logic                       adc_halt_out,       // test mode
    input  wire hsac_pkg::hsac_result_s adc_result_in,     // converter word
    output hsac_pkg::hsac_result_s     bcast_out           // labelled result
);
    hsac_pkg::hsac_state_s state;
    hsac_pkg::hsac_state_s next_state;

    logic [3:0]   reg_index;
    logic         test_mode;
    hsac_pkg::hsac_pgmode_e pg_mode;

    assign reg_index = reg_addr_in[3:0];
    assign test_mode = state.ctrl[hsac_pkg::BIT_TEST];

    always_comb begin
        if (!state.ctrl[hsac_pkg::BIT_CFG_LO]) begin
            pg_mode = hsac_pkg::HSAC_PG_OPEN_DRAIN;
        end else if (!state.ctrl[hsac_pkg::BIT_CFG_HI]) begin
            pg_mode = hsac_pkg::HSAC_PG_GP_OUT;
        end else begin
            pg_mode = hsac_pkg::HSAC_PG_GP_IN;
        end
    end

    always_comb begin
        next_state = state;
        next_state.bcast.valid = 1'b0;

        // host writes
        if (reg_wr_in) begin
            case (reg_index)
                hsac_pkg::OFS_ALERT: begin
                    next_state.alert_mask = reg_wdata_in;
                end
                hsac_pkg::OFS_CTRL: begin
                    next_state.ctrl = reg_wdata_in;
                end
                hsac_pkg::OFS_CUR_HI: begin
                    if (test_mode) begin
                        next_state.cur[9:2] = reg_wdata_in;
                    end
                end
                hsac_pkg::OFS_CUR_LO: begin
                    if (test_mode) begin
                        next_state.cur[1:0] = reg_wdata_in[7:6];
                    end
                end
                hsac_pkg::OFS_SEC_HI: begin
                    if (test_mode) begin
                        next_state.sec[9:2] = reg_wdata_in;
                    end
                end
                hsac_pkg::OFS_SEC_LO: begin
                    if (test_mode) begin
                        next_state.sec[1:0] = reg_wdata_in[7:6];
                    end
                end
                hsac_pkg::OFS_AUX_HI: begin
                    if (test_mode) begin
                        next_state.aux[9:2] = reg_wdata_in;
                    end
                end
                hsac_pkg::OFS_AUX_LO: begin
                    if (test_mode) begin
                        next_state.aux[1:0] = reg_wdata_in[7:6];
                    end
                end
                default: begin
                end
            endcase
        end

        // on pin level loaded into the fet command at end of debounce
        if (debounce_done_in) begin
            next_state.ctrl[hsac_pkg::BIT_FET_ON] = state.on_level;
        end

        // converter results, halted in test mode
        if (adc_result_in.valid && !test_mode) begin
            case (adc_result_in.label)
                hsac_pkg::LABEL_CUR: begin
                    next_state.cur = adc_result_in.data;
                end
                hsac_pkg::LABEL_SEC: begin
                    next_state.sec = adc_result_in.data;
                end
                hsac_pkg::LABEL_AUX: begin
                    next_state.aux = adc_result_in.data;
                end
                default: begin
                end
            endcase
            if (adc_result_in.label != 2'h3) begin
                next_state.bcast = adc_result_in;
            end
        end

        // host reads
        if (reg_rd_in) begin
            case (reg_index)
                hsac_pkg::OFS_ALERT:  next_state.rdata = state.alert_mask;
                hsac_pkg::OFS_CTRL:   next_state.rdata = state.ctrl;
                hsac_pkg::OFS_CUR_HI: next_state.rdata = state.cur[9:2];
                hsac_pkg::OFS_CUR_LO: next_state.rdata = {state.cur[1:0],
                                                         6'h00};
                hsac_pkg::OFS_SEC_HI: next_state.rdata = state.sec[9:2];
                hsac_pkg::OFS_SEC_LO: next_state.rdata = {state.sec[1:0],
                                                         6'h00};
                hsac_pkg::OFS_AUX_HI: next_state.rdata = state.aux[9:2];
                hsac_pkg::OFS_AUX_LO: next_state.rdata = {state.aux[1:0],
                                                         6'h00};
                default:              next_state.rdata = 8'h00;
            endcase
        end

        // pin synchronisers: a change counts once stages two and three agree
        next_state.on_sync = {state.on_sync[1:0], on_pin_in};
        if (state.on_sync[1] == state.on_sync[2]) begin
            next_state.on_level = state.on_sync[2];
        end
        next_state.pg_sync = {state.pg_sync[1:0], power_good_io_pin_in};
        if (state.pg_sync[1] == state.pg_sync[2]) begin
            next_state.pg_level = state.pg_sync[2];
        end

        // alert: any logged fault other than bit 6 whose enable is set
        next_state.alert_pull = |(fault_log_in & state.alert_mask
                                  & hsac_pkg::ALERT_EN_MASK);

        // power-good pin: open drain, only ever pulls low
        case (pg_mode)
            hsac_pkg::HSAC_PG_OPEN_DRAIN: begin
                next_state.pg_drive = 1'b0;
                next_state.pg_oe    = !power_good_in;
            end
            hsac_pkg::HSAC_PG_GP_OUT: begin
                next_state.pg_drive = 1'b0;
                next_state.pg_oe    =
                    !state.alert_mask[hsac_pkg::BIT_PG_OUT];
            end
            hsac_pkg::HSAC_PG_GP_IN: begin
                next_state.pg_drive = 1'b0;
                next_state.pg_oe    = 1'b0;
            end
            default: begin
                next_state.pg_drive = 1'b0;
                next_state.pg_oe    = 1'b0;
            end
        endcase

        if (sys_rst_in) begin
            next_state            = '0;
            next_state.alert_mask = hsac_pkg::ALERT_RST;
            next_state.ctrl       = hsac_pkg::CTRL_RST;
            next_state.cur        = hsac_pkg::RESULT_RST;
            next_state.sec        = hsac_pkg::RESULT_RST;
            next_state.aux        = hsac_pkg::RESULT_RST;
        end
    end

    always_ff @(posedge mclk_in) begin
        state <= next_state;
    end

    assign reg_rdata_out            = state.rdata;
    assign alert_pull_out           = state.alert_pull;
    assign power_good_io_pin_out    = state.pg_drive;
    assign power_good_io_pin_oe_out = state.pg_oe;
    assign pg_input_level_out       = state.pg_level;
    assign fet_on_cmd_out           = state.ctrl[hsac_pkg::BIT_FET_ON];
    assign retry_en_out             = {state.ctrl[hsac_pkg::BIT_RTY_PBAD],
                                       state.ctrl[hsac_pkg::BIT_RTY_OC],
                                       state.ctrl[hsac_pkg::BIT_RTY_UV],
                                       state.ctrl[hsac_pkg::BIT_RTY_OV]};
    assign adc_halt_out             = state.ctrl[hsac_pkg::BIT_TEST];
    assign bcast_out                = state.bcast;

    // checks
    default clocking ck @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    AST_RESET_VALUES: assert property (
        $past(sys_rst_in) |-> state.ctrl == hsac_pkg::CTRL_RST
                             && state.alert_mask == hsac_pkg::ALERT_RST)
        else $error("control or alert mask wrong after reset");

    AST_ALERT_FOLLOWS: assert property (
        ##1 alert_pull_out == |($past(fault_log_in) & $past(state.alert_mask)
                                & hsac_pkg::ALERT_EN_MASK))
        else $error("alert does not follow enabled logged faults");

    AST_PG_IN_HIZ: assert property (
        $past(pg_mode) == hsac_pkg::HSAC_PG_GP_IN && !$past(sys_rst_in)
        |-> !power_good_io_pin_oe_out)
        else $error("pin driven while configured as input");

    AST_PG_OUT_BIT: assert property (
        (pg_mode == hsac_pkg::HSAC_PG_GP_OUT && !sys_rst_in) |=>
        power_good_io_pin_oe_out == !$past(
            state.alert_mask[hsac_pkg::BIT_PG_OUT]))
        else $error("general output does not follow its bit");

    AST_LOW_ZERO: assert property (
        reg_rd_in && (reg_index == hsac_pkg::OFS_CUR_LO
                      || reg_index == hsac_pkg::OFS_SEC_LO
                      || reg_index == hsac_pkg::OFS_AUX_LO)
        |=> reg_rdata_out[5:0] == 6'h00)
        else $error("reserved result bits read nonzero");

    AST_NO_WRITE_OFF: assert property (
        reg_wr_in && !test_mode && !adc_result_in.valid
        && reg_index == hsac_pkg::OFS_CUR_HI |=> $stable(state.cur))
        else $error("result written outside test mode");

    AST_HALT: assert property (
        test_mode && adc_result_in.valid |=> !bcast_out.valid)
        else $error("conversion accepted in test mode");

    AST_FET_LOAD: assert property (
        debounce_done_in && !reg_wr_in |=>
        fet_on_cmd_out == $past(state.on_level))
        else $error("fet command not loaded from on pin");

    AST_LABEL: assert property (
        adc_result_in.valid && !test_mode && adc_result_in.label
        == hsac_pkg::LABEL_SEC |=> bcast_out.valid
        && bcast_out.label == hsac_pkg::LABEL_SEC && state.sec
        == bcast_out.data)
        else $error("broadcast label or data wrong");

    AST_POINTER_HIGH: assert property (
        reg_wr_in && reg_addr_in[3:0] == hsac_pkg::OFS_ALERT
        |=> state.alert_mask == $past(reg_wdata_in))
        else $error("upper pointer bits not ignored");

    AST_SYNC_FILTER: assert property (
        !state.on_sync[1] && !state.on_sync[2] |=> !state.on_level)
        else $error("on pin filter did not settle");

    AST_RETRY_WRITE: assert property (
        reg_wr_in && reg_index == hsac_pkg::OFS_CTRL |=>
        retry_en_out == {$past(reg_wdata_in[hsac_pkg::BIT_RTY_PBAD]),
                         $past(reg_wdata_in[hsac_pkg::BIT_RTY_OC]),
                         $past(reg_wdata_in[hsac_pkg::BIT_RTY_UV]),
                         $past(reg_wdata_in[hsac_pkg::BIT_RTY_OV])})
        else $error("retry enables do not follow the control write");

    AST_TEST_WRITE: assert property (
        reg_wr_in && reg_index == hsac_pkg::OFS_CTRL |=>
        adc_halt_out == $past(reg_wdata_in[hsac_pkg::BIT_TEST]))
        else $error("test mode output does not follow the control write");

    AST_FET_WRITE: assert property (
        reg_wr_in && reg_index == hsac_pkg::OFS_CTRL && !debounce_done_in
        |=> fet_on_cmd_out == $past(reg_wdata_in[hsac_pkg::BIT_FET_ON]))
        else $error("fet command does not follow the control write");

    AST_MASK_READ: assert property (
        reg_rd_in && reg_index == hsac_pkg::OFS_ALERT
        |=> reg_rdata_out == $past(state.alert_mask))
        else $error("alert mask read back wrong");

    AST_CTRL_READ_HIGH: assert property (
        reg_rd_in && reg_addr_in[7:4] != 4'h0
        && reg_addr_in[3:0] == hsac_pkg::OFS_CTRL
        |=> reg_rdata_out == $past(state.ctrl))
        else $error("upper pointer bits change the read target");

    AST_CUR_HI_READ: assert property (
        reg_rd_in && reg_index == hsac_pkg::OFS_CUR_HI
        |=> reg_rdata_out == $past(state.cur[9:2]))
        else $error("current result high byte read wrong");

    AST_SEC_LO_READ: assert property (
        reg_rd_in && reg_index == hsac_pkg::OFS_SEC_LO
        |=> reg_rdata_out[7:6] == $past(state.sec[1:0]))
        else $error("second input low bits read wrong");

    AST_AUX_HI_READ: assert property (
        reg_rd_in && reg_index == hsac_pkg::OFS_AUX_HI
        |=> reg_rdata_out == $past(state.aux[9:2]))
        else $error("aux input high byte read wrong");

    AST_CUR_TAKE: assert property (
        adc_result_in.valid && !test_mode
        && adc_result_in.label == hsac_pkg::LABEL_CUR
        |=> state.cur == $past(adc_result_in.data))
        else $error("current result not taken from converter");

    AST_AUX_LABEL: assert property (
        adc_result_in.valid && !test_mode
        && adc_result_in.label == hsac_pkg::LABEL_AUX
        |=> bcast_out.valid && bcast_out.label == hsac_pkg::LABEL_AUX
        && bcast_out.data == $past(adc_result_in.data))
        else $error("aux broadcast label or data wrong");

    AST_LABEL_DROP: assert property (
        adc_result_in.valid && adc_result_in.label == 2'h3
        |=> !bcast_out.valid)
        else $error("unlabelled result broadcast");

    AST_LO_WRITE: assert property (
        reg_wr_in && test_mode && reg_index == hsac_pkg::OFS_CUR_LO
        |=> state.cur[1:0] == $past(reg_wdata_in[7:6])
        && state.cur[9:2] == $past(state.cur[9:2]))
        else $error("low result write touched reserved or high bits");

    AST_NO_WRITE_SEC: assert property (
        reg_wr_in && !test_mode && !adc_result_in.valid
        && reg_index == hsac_pkg::OFS_SEC_LO |=> $stable(state.sec))
        else $error("second input result written outside test mode");

    AST_PG_DRAIN: assert property (
        pg_mode == hsac_pkg::HSAC_PG_OPEN_DRAIN
        |=> power_good_io_pin_oe_out == !$past(power_good_in))
        else $error("power-good pull does not follow power good");

    AST_PG_NEVER_HIGH: assert property (
        !power_good_io_pin_out)
        else $error("open-drain pin driven high");

    CVR_TEST_WRITE: cover property (
        test_mode && reg_wr_in && reg_index == hsac_pkg::OFS_AUX_LO);
    CVR_ALERT: cover property (alert_pull_out ##1 !alert_pull_out);
    CVR_GP_OUT: cover property (pg_mode == hsac_pkg::HSAC_PG_GP_OUT
                                ##1 power_good_io_pin_oe_out);
    CVR_FET_LOAD: cover property (debounce_done_in ##1 fet_on_cmd_out);
    CVR_AUX_BCAST: cover property (
        bcast_out.valid && bcast_out.label == hsac_pkg::LABEL_AUX);
endmodule

//--- verification/hsac_far_model.sv
// converter source and power-good pin wire model for the register bank
`timescale 1ns/1ps
module hsac_far_model (
    input  wire logic              mclk_in,       // bank clock
    input  wire logic              pin_oe_in,     // bank pulls the pin
    input  wire logic              pin_drv_in,    // bank drive value
    input  wire logic              ext_low_in,    // board pulls pin low
    output logic                   pin_level_out, // resolved pin level
    output hsac_pkg::hsac_result_s result_out     // converter word
);
    // pull-up holds the wire high unless some party pulls it low
    assign pin_level_out = !(pin_oe_in && !pin_drv_in) && !ext_low_in;

    initial result_out = '0;

    // one-cycle result pulse; data scrambled once the word is gone
    task automatic send(input logic [1:0] lbl, input logic [9:0] d);
        @(posedge mclk_in);
        #1;
        result_out = {1'b1, lbl, d};
        @(posedge mclk_in);
        #1;
        result_out.valid = 1'b0;
        result_out.data  = ~d;
    endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the alert, control and adc result register bank
`timescale 1ns/1ps
module tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic [7:0]             addr = 8'h00;
    logic [7:0]             wd = 8'h00;
    logic [7:0]             rdata;
    logic [7:0]             flt = 8'h00;
    logic                   alert;
    logic                   pg_good = 1'b1;
    logic                   pin_lvl;
    logic                   pin_drv;
    logic                   pin_oe;
    logic                   pin_filt;
    logic                   ext_low = 1'b0;
    logic                   on_pin = 1'b0;
    logic                   deb = 1'b0;
    logic                   fet;
    hsac_pkg::hsac_retry_s  rty;
    logic                   halt;
    hsac_pkg::hsac_result_s res;
    hsac_pkg::hsac_result_s bc;
    int                     err_total = 0;
    int                     n_tests = 0;
    int                     cycles = 0;

    hsac_regs DUT (
        .mclk_in(clk), .sys_rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
        .fault_log_in(flt), .alert_pull_out(alert),
        .power_good_in(pg_good), .power_good_io_pin_in(pin_lvl),
        .power_good_io_pin_out(pin_drv),
        .power_good_io_pin_oe_out(pin_oe), .pg_input_level_out(pin_filt),
        .on_pin_in(on_pin), .debounce_done_in(deb), .fet_on_cmd_out(fet),
        .retry_en_out(rty), .adc_halt_out(halt), .adc_result_in(res),
        .bcast_out(bc)
    );

    hsac_far_model far (
        .mclk_in(clk), .pin_oe_in(pin_oe), .pin_drv_in(pin_drv),
        .ext_low_in(ext_low), .pin_level_out(pin_lvl), .result_out(res)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic t_reset();
        rreg(8'h02, 8'h00);
        rreg(8'h03, 8'h03);
        chk({12'h000, rty}, 16'h0003);
        for (int a = 4; a < 10; a++) rreg(8'(a), 8'h00);
    endtask

    task automatic t_ctrl();
        wreg(8'hF3, 8'h14);
        cyc(1);
        chk({12'h000, rty}, 16'h000C);
        wreg(8'h03, 8'h0B);
        cyc(1);
        chk({14'h0, fet, halt}, 16'h0002);
        chk({12'h000, rty}, 16'h0003);
        rreg(8'hA3, 8'h0B);
        wreg(8'h0A, 8'h55);
        rreg(8'h0A, 8'h00);
    endtask

    task automatic t_adc();
        logic [9:0] v[3] = '{10'h2B5, 10'h13E, 10'h3C2};
        for (int i = 0; i < 3; i++) begin
            far.send(2'(i), v[i]);
            chk({3'h0, bc}, {3'h0, 1'b1, 2'(i), v[i]});
            cyc(1);
            rreg(8'(4 + 2 * i), v[i][9:2]);
            rreg(8'(5 + 2 * i), {v[i][1:0], 6'h00});
        end
        far.send(2'h3, 10'h155);
        chk({15'h0, bc.valid}, 16'h0000);
        rreg(8'h08, v[2][9:2]);
    endtask

    task automatic t_test_mode();
        wreg(8'h03, 8'h23);
        cyc(1);
        chk({15'h0, halt}, 16'h0001);
        wreg(8'h04, 8'h5A);
        wreg(8'h05, 8'hFF);
        far.send(2'h0, 10'h3FF);
        chk({15'h0, bc.valid}, 16'h0000);
        rreg(8'h04, 8'h5A);
        rreg(8'h05, 8'hC0);
        wreg(8'h03, 8'h03);
        wreg(8'h04, 8'h11);
        rreg(8'h04, 8'h5A);
    endtask

    task automatic t_alert();
        for (int b = 0; b < 8; b++) begin
            wreg(8'h02, 8'h00);
            flt = 8'(1 << b);
            cyc(3);
            chk({15'h0, alert}, 16'h0000);
            wreg(8'h02, 8'(1 << b));
            cyc(2);
            chk({15'h0, alert}, {15'h0, b != 6});
        end
        flt = 8'h00;
        wreg(8'h02, 8'h00);
    endtask

    task automatic t_pin();
        pg_good = 1'b0;
        cyc(3);
        chk({15'h0, pin_oe}, 16'h0001);
        wreg(8'h03, 8'h83);
        cyc(1);
        chk({15'h0, pin_oe}, 16'h0001);
        pg_good = 1'b1;
        cyc(2);
        chk({15'h0, pin_oe}, 16'h0000);
        wreg(8'h03, 8'h43);
        cyc(2);
        chk({14'h0, pin_oe, pin_lvl}, 16'h0002);
        wreg(8'h02, 8'h40);
        cyc(2);
        chk({14'h0, pin_oe, pin_lvl}, 16'h0001);
        wreg(8'h03, 8'hC3);
        ext_low = 1'b1;
        cyc(7);
        chk({14'h0, pin_oe, pin_filt}, 16'h0000);
        ext_low = 1'b0;
        cyc(7);
        chk({14'h0, pin_oe, pin_filt}, 16'h0001);
    endtask

    task automatic t_fet();
        for (int k = 0; k < 2; k++) begin
            on_pin = (k == 0);
            cyc(8);
            deb = 1'b1;
            cyc(1);
            deb = 1'b0;
            cyc(2);
            chk({15'h0, fet}, {15'h0, k == 0});
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        cyc(10);
        rst = 1'b0;
        t_reset();
        t_ctrl();
        t_adc();
        t_test_mode();
        t_alert();
        t_pin();
        t_fet();
        // second reset over non-default contents
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        t_reset();
        conclude();
    end
endmodule
